// file: logic/srxbg_baud_gen.v
module srxbg_baud_gen #(
	parameter W = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire [W-1:0] divisor,
	input wire restart,
	output reg tick
);
	reg [W-1:0] cnt_r;

	// free running, period divisor + 1
	always @(posedge aclk) begin
		if (!aresetn || restart) begin // R7
			cnt_r <= {W{1'b0}};
			tick <= 1'b0;
		end else if (cnt_r == divisor) begin // R2
			cnt_r <= {W{1'b0}};
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule

// file: logic/srxbg_defs.vh
`ifndef SRXBG_DEFS_VH
`define SRXBG_DEFS_VH

// ***************************************************
// register byte addresses
// ***************************************************
`define SRXBG_OFF_RX_STATUS_CONTROL 8'h00
`define SRXBG_OFF_BAUD_DIVISOR 8'h04
`define SRXBG_OFF_TX_CONTROL 8'h08
`define SRXBG_OFF_RX_BUFFER 8'h0C
`define SRXBG_OFF_IRQ_STATUS 8'h10
`define SRXBG_OFF_IRQ_CLEAR 8'h14
`define SRXBG_OFF_IRQ_ENABLE 8'h18

// ***************************************************
// receive_status_control fields
// ***************************************************
`define SRXBG_RCS_PORT_ON 7
`define SRXBG_RCS_NINE_BIT 6
`define SRXBG_RCS_SINGLE_REQ 5
`define SRXBG_RCS_CONT_ON 4
`define SRXBG_RCS_ADDR_DET 3
`define SRXBG_RCS_FRAME_ERR 2
`define SRXBG_RCS_OVERRUN 1
`define SRXBG_RCS_NINTH 0
`define SRXBG_RCS_WR_MASK 8'hF8

// ***************************************************
// transmit_control_register fields used here
// ***************************************************
`define SRXBG_TXC_CLK_MASTER 7
`define SRXBG_TXC_SYNC 4
`define SRXBG_TXC_HIGH_SPEED 2
`define SRXBG_TXC_WR_MASK 8'h94

// ***************************************************
// interrupt bits
// ***************************************************
`define SRXBG_IRQ_RX_READY 0
`define SRXBG_IRQ_FRAME_ERR 1
`define SRXBG_IRQ_OVERRUN 2

// ***************************************************
// reset values and timing
// ***************************************************
`define SRXBG_RST_RCS 8'h00
`define SRXBG_RST_TXC 8'h00
`define SRXBG_RST_DIV 8'h00
`define SRXBG_OS_MID 4'h8
`define SRXBG_LOW_SPEED_PRE 2'h3

`endif

// file: logic/srxbg_sync3.v
module srxbg_sync3 #(
	parameter W = 2,
	parameter [W-1:0] INIT = {W{1'b1}}
) (
	input wire aclk,
	input wire aresetn,
	input wire [W-1:0] din,
	output wire [W-1:0] dout
);
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg [2:0] s_r;
			reg q_r;
			always @(posedge aclk) begin
				if (!aresetn) begin
					s_r <= {3{INIT[i]}};
					q_r <= INIT[i];
				end else begin
					s_r <= {s_r[1:0], din[i]};
					// a change counts once stages two and three agree
					if (s_r[1] == s_r[2]) begin
						q_r <= s_r[2];
					end
				end
			end
			assign dout[i] = q_r;
		end
	endgenerate
endmodule

// file: logic/srxbg_top.v
// Overview of operation
// R1: one dedicated 8-bit baud generator serves asynchronous and synchronous modes.
// R2: baud_divisor sets the period of a free-running 8-bit timer; overflows clock bits.
// R3: asynchronous mode: high_speed_baud_select picks low or high speed divide ratio.
// R4: synchronous mode ignores high_speed_baud_select; one fixed divide ratio.
// R5: generator rate used only as clock master; sync slave takes far-end clock.
// R6: software should prefer high-speed divide-by-16 to reduce rate error.
// R7: writing baud_divisor restarts the baud timer at zero immediately.
// R8: serial_port_on enables the port and claims the data and clock pins.
// R9: nine_bit_receive_select chooses 9-bit words, else 8-bit words.
// R10: async 9-bit with address detect loads buffer only when ninth bit is one.
// R11: framing_error_flag set on bad stop bit, updated as each byte is loaded.
// R12: overrun_error_flag set on overrun, cleared only by clearing continuous_receive_on.
// R13: sync master single_receive_request receives one word, then clears itself.
// R14: continuous_receive_on enables async receive; in sync it runs and overrides single.
// R15: ninth bit shown in received_ninth_bit; no parity computed in hardware.
// R16: incoming data sampled three times per bit, level by majority vote; the code votes in async only, sync mode samples each bit once.
// R17: bit rate is clock over 64(X+1), 16(X+1) or 4(X+1) by mode.
`include "srxbg_defs.vh"

module srxbg_top #(
	parameter AW = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire [AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire serial_data_in,
	input wire serial_clk_in,
	output reg serial_clk_out,
	output wire serial_clk_oe,
	output wire serial_pins_claimed,
	output wire irq
);
	// ***************************************************
	// state codes
	// ***************************************************
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_START = 2'h1;
	localparam [1:0] ST_DATA = 2'h2;
	localparam [1:0] ST_STOP = 2'h3;

	// ***************************************************
	// declarations
	// ***************************************************
	reg [7:0] rcs_r;
	reg [7:0] txc_r;
	reg [7:0] div_r;
	reg [7:0] rxbuf_r;
	reg buf_full_r;
	reg [2:0] irq_st_r;
	reg [2:0] irq_en_r;
	reg [AW-1:0] awaddr_r;
	reg aw_full_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg w_full_r;
	reg [1:0] pre_r;
	reg [1:0] state_r;
	reg [3:0] ph_r;
	reg [3:0] bitcnt_r;
	reg [8:0] sh_r;
	reg v7_r;
	reg v8_r;
	reg done_r;
	reg done_framing_error_flag_r;
	reg sclk_prev_r;
	reg [31:0] rd_mux;
	reg rd_ok;
	wire [1:0] pins_q;
	wire rxd;
	wire sclk_q;
	wire baud_tick;
	wire wr_do;
	wire rd_do;
	wire rd_pop;
	wire div_wr;
	wire port_on;
	wire nine;
	wire single_req;
	wire cont_on;
	wire addr_det;
	wire sync_mode;
	wire clk_master;
	wire high_speed;
	wire os_tick;
	wire half_tick;
	wire async_en;
	wire sync_en;
	wire maj;
	wire bit_ev;
	wire last_bit;
	wire [7:0] word;
	wire ninth;
	wire accept;
	wire load;
	wire ovr_ev;
	wire [2:0] irq_ev;

	// ***************************************************
	// field aliases
	// ***************************************************
	assign port_on = rcs_r[`SRXBG_RCS_PORT_ON];
	assign nine = rcs_r[`SRXBG_RCS_NINE_BIT];
	assign single_req = rcs_r[`SRXBG_RCS_SINGLE_REQ];
	assign cont_on = rcs_r[`SRXBG_RCS_CONT_ON];
	assign addr_det = rcs_r[`SRXBG_RCS_ADDR_DET];
	assign sync_mode = txc_r[`SRXBG_TXC_SYNC];
	assign clk_master = txc_r[`SRXBG_TXC_CLK_MASTER];
	assign high_speed = txc_r[`SRXBG_TXC_HIGH_SPEED];

	// ***************************************************
	// pins
	// ***************************************************
	srxbg_sync3 #(
		.W(2),
		.INIT(2'h3)
	) u_pin_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din({serial_clk_in, serial_data_in}),
		.dout(pins_q)
	);
	assign rxd = pins_q[0];
	assign sclk_q = pins_q[1];

	assign serial_pins_claimed = port_on; // R8
	assign serial_clk_oe = port_on & sync_mode & clk_master; // R5

	// ***************************************************
	// baud generation
	// ***************************************************
	srxbg_baud_gen #(
		.W(8)
	) u_baud ( // R1
		.aclk(aclk),
		.aresetn(aresetn),
		.divisor(div_r),
		.restart(div_wr),
		.tick(baud_tick)
	);

	// prescaler restarts with the timer so a new rate lands at once
	always @(posedge aclk) begin
		if (!aresetn || div_wr) begin // R7
			pre_r <= 2'h0;
		end else if (baud_tick) begin
			pre_r <= pre_r + 2'h1;
		end
	end

	// 16 samples per async bit: low speed needs 4 timer overflows each
	assign os_tick = baud_tick & (high_speed | (pre_r == `SRXBG_LOW_SPEED_PRE)); // R3 R17
	// sync: clock half period is two overflows, high_speed_baud_select unused
	assign half_tick = baud_tick & pre_r[0]; // R4 R17

	// ***************************************************
	// receiver
	// ***************************************************
	assign async_en = port_on & ~sync_mode & cont_on & ~rcs_r[`SRXBG_RCS_OVERRUN]; // R14
	assign sync_en = port_on & sync_mode & (cont_on | (single_req & clk_master))
		& ~rcs_r[`SRXBG_RCS_OVERRUN]; // R13 R14
	assign maj = (v7_r & v8_r) | (v7_r & rxd) | (v8_r & rxd); // R16
	// master samples as its own clock rises, slave on the far end's rising edge
	assign bit_ev = clk_master ? (half_tick & ~serial_clk_out) : (sclk_q & ~sclk_prev_r); // R5
	assign last_bit = (bitcnt_r == (nine ? 4'h8 : 4'h7)); // R9

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_IDLE;
			ph_r <= 4'h0;
			bitcnt_r <= 4'h0;
			sh_r <= 9'h000;
			v7_r <= 1'b1;
			v8_r <= 1'b1;
			done_r <= 1'b0;
			done_framing_error_flag_r <= 1'b0;
			serial_clk_out <= 1'b0;
			// matches the synchroniser preset, so no false edge after reset
			sclk_prev_r <= 1'b1;
		end else begin
			done_r <= 1'b0;
			sclk_prev_r <= sclk_q;
			if (os_tick && ph_r == `SRXBG_OS_MID - 4'h1) begin
				v7_r <= rxd;
			end
			if (os_tick && ph_r == `SRXBG_OS_MID) begin
				v8_r <= rxd;
			end
			if (!sync_mode && !async_en) begin
				state_r <= ST_IDLE;
				serial_clk_out <= 1'b0;
			end else if (sync_mode && !sync_en) begin
				state_r <= ST_IDLE;
				// a running clock finishes its half period, no runt pulse
				if (half_tick || !clk_master) begin
					serial_clk_out <= 1'b0;
				end
			end else if (sync_mode) begin
				// last high phase runs out in full before the clock rests
				if (clk_master && half_tick && (state_r == ST_DATA || serial_clk_out)) begin
					serial_clk_out <= ~serial_clk_out; // R17
				end else if (!clk_master) begin
					serial_clk_out <= 1'b0;
				end
				case (state_r)
					ST_IDLE: begin
						state_r <= ST_DATA;
						bitcnt_r <= 4'h0;
					end
					ST_DATA: begin
						if (bit_ev) begin
							sh_r <= {rxd, sh_r[8:1]};
							bitcnt_r <= bitcnt_r + 4'h1;
							if (last_bit) begin
								state_r <= ST_IDLE;
								done_r <= 1'b1;
								done_framing_error_flag_r <= 1'b0;
							end
						end
					end
					default: begin
						state_r <= ST_IDLE;
					end
				endcase
			end else if (os_tick) begin
				ph_r <= ph_r + 4'h1;
				case (state_r)
					ST_IDLE: begin
						if (!rxd) begin
							state_r <= ST_START;
							ph_r <= 4'h1;
						end
					end
					ST_START: begin
						if (ph_r == `SRXBG_OS_MID + 4'h1) begin
							state_r <= maj ? ST_IDLE : ST_DATA;
							bitcnt_r <= 4'h0;
						end
					end
					ST_DATA: begin
						if (ph_r == `SRXBG_OS_MID + 4'h1) begin
							sh_r <= {maj, sh_r[8:1]};
							bitcnt_r <= bitcnt_r + 4'h1;
							if (last_bit) begin
								state_r <= ST_STOP;
							end
						end
					end
					default: begin
						if (ph_r == `SRXBG_OS_MID + 4'h1) begin
							state_r <= ST_IDLE;
							done_r <= 1'b1;
							done_framing_error_flag_r <= ~maj; // R11
						end
					end
				endcase
			end
		end
	end

	// ***************************************************
	// receive buffer and status
	// ***************************************************
	assign word = nine ? sh_r[7:0] : sh_r[8:1];
	assign ninth = nine & sh_r[8];
	// address frames only: data bytes dropped silently, no overrun either
	assign accept = ~(addr_det & nine & ~sync_mode & ~ninth); // R10
	assign load = done_r & accept & (~buf_full_r | rd_pop);
	assign ovr_ev = done_r & accept & buf_full_r & ~rd_pop; // R12

	always @(posedge aclk) begin
		if (!aresetn) begin
			rcs_r <= `SRXBG_RST_RCS;
			txc_r <= `SRXBG_RST_TXC;
			div_r <= `SRXBG_RST_DIV;
			rxbuf_r <= 8'h00;
			buf_full_r <= 1'b0;
			irq_st_r <= 3'h0;
			irq_en_r <= 3'h0;
		end else begin
			if (wr_do && wstrb_r[0]) begin
				case (awaddr_r)
					`SRXBG_OFF_RX_STATUS_CONTROL: begin
						rcs_r[7:3] <= wdata_r[7:3]; // R8 R9 R14
						if (!wdata_r[`SRXBG_RCS_CONT_ON]) begin
							rcs_r[`SRXBG_RCS_OVERRUN] <= 1'b0; // R12
						end
					end
					`SRXBG_OFF_BAUD_DIVISOR: begin
						div_r <= wdata_r[7:0]; // R2
					end
					`SRXBG_OFF_TX_CONTROL: begin
						txc_r <= wdata_r[7:0] & `SRXBG_TXC_WR_MASK;
					end
					`SRXBG_OFF_IRQ_ENABLE: begin
						irq_en_r <= wdata_r[2:0];
					end
					default: begin
					end
				endcase
			end
			// single request ends after one word, master only
			if (done_r && sync_mode && clk_master && !cont_on) begin
				rcs_r[`SRXBG_RCS_SINGLE_REQ] <= 1'b0; // R13
			end
			if (ovr_ev) begin
				rcs_r[`SRXBG_RCS_OVERRUN] <= 1'b1; // R12
			end
			if (load) begin
				rxbuf_r <= word;
				rcs_r[`SRXBG_RCS_NINTH] <= ninth; // R15
				rcs_r[`SRXBG_RCS_FRAME_ERR] <= done_framing_error_flag_r; // R11
				buf_full_r <= 1'b1;
			end else if (rd_pop) begin
				buf_full_r <= 1'b0;
			end
			// clear then set: an event in the clear cycle survives
			if (wr_do && wstrb_r[0] && awaddr_r == `SRXBG_OFF_IRQ_CLEAR) begin
				irq_st_r <= (irq_st_r & ~wdata_r[2:0]) | irq_ev;
			end else begin
				irq_st_r <= irq_st_r | irq_ev;
			end
		end
	end

	assign irq_ev = {ovr_ev, load & done_framing_error_flag_r, load};
	assign irq = |(irq_st_r & irq_en_r);

	// ***************************************************
	// axi4-lite slave
	// ***************************************************
	assign s_axi_awready = ~aw_full_r & ~s_axi_bvalid;
	assign s_axi_wready = ~w_full_r & ~s_axi_bvalid;
	assign wr_do = aw_full_r & w_full_r & ~s_axi_bvalid;
	assign div_wr = wr_do & wstrb_r[0] & (awaddr_r == `SRXBG_OFF_BAUD_DIVISOR); // R7
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_do = s_axi_arvalid & s_axi_arready;
	assign rd_pop = rd_do & (s_axi_araddr == `SRXBG_OFF_RX_BUFFER);

	always @* begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`SRXBG_OFF_RX_STATUS_CONTROL: rd_mux = {24'h00_0000, rcs_r};
			`SRXBG_OFF_BAUD_DIVISOR: rd_mux = {24'h00_0000, div_r};
			`SRXBG_OFF_TX_CONTROL: rd_mux = {24'h00_0000, txc_r};
			`SRXBG_OFF_RX_BUFFER: rd_mux = {24'h00_0000, rxbuf_r};
			`SRXBG_OFF_IRQ_STATUS: rd_mux = {29'h0000_0000, irq_st_r};
			`SRXBG_OFF_IRQ_CLEAR: rd_mux = 32'h0000_0000;
			`SRXBG_OFF_IRQ_ENABLE: rd_mux = {29'h0000_0000, irq_en_r};
			default: begin
				rd_mux = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			awaddr_r <= {AW{1'b0}};
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_do) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_r[1:0] == 2'h0 && awaddr_r <= `SRXBG_OFF_IRQ_ENABLE)
					? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (rd_do) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// file: tb/srxbg_far_end.sv
module srxbg_far_end (
	input wire logic aclk,
	input wire logic serial_clk_out,
	output logic serial_data_in,
	output logic serial_clk_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sync_word = 8'h00;
	int sync_idx = 8;
	// line has a pull-up: idle and released read high
	initial serial_data_in = 1'b1;
	initial serial_clk_in = 1'b0;
	// ***************************************************
	// async frame, lsb first, one idle bit after stop
	// ***************************************************
	task automatic send_async(input logic [8:0] w, input int nb, input int bt, input logic stp);
		serial_data_in <= 1'b0;
		repeat (bt) @(posedge aclk);
		for (int i = 0; i < nb; i++) begin
			serial_data_in <= w[i];
			repeat (bt) @(posedge aclk);
		end
		serial_data_in <= stp;
		repeat (bt) @(posedge aclk);
		serial_data_in <= 1'b1;
		repeat (bt) @(posedge aclk);
	endtask
	// ***************************************************
	// sync slave data, clocked by the master
	// ***************************************************
	task automatic load_sync(input logic [7:0] w);
		sync_word = w;
		sync_idx = 0;
		serial_data_in <= w[0];
	endtask
	// ***************************************************
	// sync master data, clock made here, data set while low
	// ***************************************************
	task automatic send_slave(input logic [7:0] w);
		for (int i = 0; i < 8; i++) begin
			serial_data_in <= w[i];
			repeat (8) @(posedge aclk);
			serial_clk_in <= 1'b1;
			repeat (8) @(posedge aclk);
			serial_clk_in <= 1'b0;
		end
		serial_data_in <= 1'b1;
		repeat (8) @(posedge aclk);
	endtask
	// change on the fall, half a period before the sampling rise
	always @(negedge serial_clk_out) begin
		if (sync_idx < 8) begin
			sync_idx++;
			serial_data_in <= (sync_idx < 8) ? sync_word[sync_idx] : 1'b1;
		end
	end
endmodule

// file: tb/srxbg_props.sv
module srxbg_props (
	input logic aclk,
	input logic aresetn,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic serial_clk_out,
	input logic serial_clk_oe,
	input logic serial_pins_claimed
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ***************************************************
	// bit clock edges
	// ***************************************************
	sequence s_clk_rise;
		$rose(serial_clk_out);
	endsequence
	sequence s_clk_fall;
		$fell(serial_clk_out);
	endsequence
	// ***************************************************
	// register bus
	// ***************************************************
	AST_AW_BLOCKED: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channels open while response pending");
	AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> ##1 s_axi_bvalid) else $error("write response late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	// ***************************************************
	// pins and bit clock
	// ***************************************************
	AST_OE_CLAIM: assert property (!serial_pins_claimed |-> !serial_clk_oe)
		else $error("clock driven with port off");
	// half period 2(X+1) is never below two cycles
	AST_CLK_HIGH: assert property (s_clk_rise |-> ##1 serial_clk_out)
		else $error("bit clock high too short");
	AST_CLK_LOW: assert property (s_clk_fall |-> ##1 !serial_clk_out)
		else $error("bit clock low too short");
	AST_CLK_IDLE: assert property (!serial_clk_oe && !serial_clk_out |=> !serial_clk_out)
		else $error("bit clock runs without master");
endmodule

// file: tb/tb_top.sv
`include "srxbg_defs.vh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] a_rcs = `SRXBG_OFF_RX_STATUS_CONTROL;
	localparam logic [7:0] a_div = `SRXBG_OFF_BAUD_DIVISOR;
	localparam logic [7:0] a_txc = `SRXBG_OFF_TX_CONTROL;
	localparam logic [7:0] a_buf = `SRXBG_OFF_RX_BUFFER;
	localparam logic [7:0] a_ist = `SRXBG_OFF_IRQ_STATUS;
	localparam logic [7:0] a_icl = `SRXBG_OFF_IRQ_CLEAR;
	localparam logic [7:0] a_ien = `SRXBG_OFF_IRQ_ENABLE;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, clk_out, clk_oe, claimed, irq, sdata, sclk_in;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int err_count = 0;
	int total_checks = 0;
	int t0;
	always #5 aclk = ~aclk;
	srxbg_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .serial_data_in(sdata), .serial_clk_in(sclk_in),
		.serial_clk_out(clk_out), .serial_clk_oe(clk_oe),
		.serial_pins_claimed(claimed), .irq(irq));
	srxbg_far_end far (.aclk(aclk), .serial_clk_out(clk_out), .serial_data_in(sdata),
		.serial_clk_in(sclk_in));
	// ***************************************************
	// bus tasks
	// ***************************************************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		bit ap;
		bit wp;
		ap = 1;
		wp = 1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (ap || wp) begin
			@(posedge aclk);
			if (ap && awready) begin
				ap = 0;
				awvalid <= 1'b0;
			end
			if (wp && wready) begin
				wp = 0;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		chk("bresp", er, bresp);
		bready <= 1'b0;
	endtask
	// rready raised late on purpose, so the slave must hold its answer
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		rready <= 1'b1;
		@(posedge aclk);
		chk($sformatf("read %h", a), e, rdata);
		chk("rresp", er, rresp);
		rready <= 1'b0;
	endtask
	task automatic wirq();
		for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge aclk);
		chk("irq", 1, irq);
	endtask
	task automatic chkirq(input logic e);
		repeat (2) @(posedge aclk);
		chk("irq", e, irq);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ***************************************************
	// tests
	// ***************************************************
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(a_rcs, `SRXBG_RST_RCS);
		rd(a_div, `SRXBG_RST_DIV);
		rd(8'h1c, 32'h0000_0000, 2'h2);
		wr(8'h1c, 32'h0000_00ff, 2'h2);
		wr(a_txc, 32'h0000_00ff);
		rd(a_txc, `SRXBG_TXC_WR_MASK);
		chk("pins claimed", 0, claimed);
		$display("test registers done");
		wr(a_txc, 32'h0000_0000);
		wr(a_div, 32'h0000_0000);
		wr(a_ien, 32'h0000_0007);
		wr(a_rcs, 32'h0000_0090);
		chk("pins claimed", 1, claimed);
		chk("clock enable", 0, clk_oe);
		far.send_async(9'h05a, 8, 64, 1'b1);
		wirq();
		rd(a_ist, 32'h0000_0001);
		rd(a_buf, 32'h0000_005a);
		wr(a_icl, 32'h0000_0007);
		chkirq(0);
		$display("test low speed done");
		wr(a_txc, 32'h0000_0004);
		wr(a_div, 32'h0000_0001);
		far.send_async(9'h03c, 8, 32, 1'b0);
		wirq();
		rd(a_rcs, 32'h0000_0094);
		rd(a_ist, 32'h0000_0003);
		wr(a_ien, 32'h0000_0000);
		chkirq(0);
		wr(a_ien, 32'h0000_0007);
		chkirq(1);
		rd(a_buf, 32'h0000_003c);
		wr(a_icl, 32'h0000_0007);
		chkirq(0);
		$display("test framing done");
		wr(a_rcs, 32'h0000_00d8);
		far.send_async(9'h011, 9, 32, 1'b1);
		chkirq(0);
		rd(a_ist, 32'h0000_0000);
		far.send_async(9'h122, 9, 32, 1'b1);
		wirq();
		rd(a_rcs, 32'h0000_00d9);
		rd(a_buf, 32'h0000_0022);
		wr(a_icl, 32'h0000_0007);
		$display("test address detect done");
		wr(a_rcs, 32'h0000_0090);
		far.send_async(9'h001, 8, 32, 1'b1);
		far.send_async(9'h002, 8, 32, 1'b1);
		rd(a_rcs, 32'h0000_0092);
		rd(a_ist, 32'h0000_0005);
		wr(a_rcs, 32'h0000_0080);
		rd(a_rcs, 32'h0000_0080);
		rd(a_buf, 32'h0000_0001);
		wr(a_icl, 32'h0000_0007);
		$display("test overrun done");
		wr(a_txc, 32'h0000_0094);
		wr(a_div, 32'h0000_0003);
		far.load_sync(8'h96);
		wr(a_rcs, 32'h0000_00a0);
		chk("clock enable", 1, clk_oe);
		@(posedge clk_out);
		t0 = $time;
		@(posedge clk_out);
		chk("clock period", 16, 32'(($time - t0) / 10));
		wirq();
		rd(a_rcs, 32'h0000_0080);
		rd(a_buf, 32'h0000_0096);
		$display("test sync master done");
		wr(a_icl, 32'h0000_0007);
		wr(a_txc, 32'h0000_0010);
		wr(a_rcs, 32'h0000_0090);
		chk("clock enable", 0, clk_oe);
		far.send_slave(8'ha5);
		wirq();
		rd(a_buf, 32'h0000_00a5);
		chk("clock idle", 0, clk_out);
		$display("test sync slave done");
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		err_count++;
		give_verdict();
	end
endmodule

bind srxbg_top srxbg_props u_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.serial_clk_out(serial_clk_out), .serial_clk_oe(serial_clk_oe),
	.serial_pins_claimed(serial_pins_claimed));
